// ---- gpio_output_and_access_masks.sv ----
// gpio output value, network write mask and eeprom usage/service control registers
`timescale 1ns/1ns
`default_nettype none
module gpio_output_and_access_masks
    import gpio_mask_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire wb_req_t wbReq,
    output logic [WB_DAT_W-1:0] wbDatO,
    output logic wbAck,
    input wire logic [1:0] serialStrap,
    input wire logic [15:0] gpioDirection,
    input wire logic [15:0] gpioAltSelect,
    input wire net_gpio_wr_t netGpioWr,
    input wire net_eep_wr_t netEepWr,
    output logic [15:0] gpioPinOut,
    output logic [15:0] gpioPinOe,
    output logic eepWrEn,
    output logic [7:0] eepWrAddr,
    output logic [15:0] eepWrData,
    output logic eepWrRefused,
    output logic echoReplyDisable,
    output logic fileTransferDisable,
    output logic webServerDisable,
    output logic mgmtServerDisable,
    output logic [3:0] eepromUsageCode,
    output logic mibModeActive,
    input wire logic descrStart,
    input wire logic oidStart,
    input wire logic [15:0] descrRdData,
    input wire logic [15:0] oidRdData,
    output logic descrRdReq,
    output logic [7:0] descrRdAddr,
    output logic oidRdReq,
    output logic [7:0] oidRdAddr,
    output str_byte_t descrByte,
    output str_byte_t oidByte
);
    logic [15:0] gpioValue_ff, nxt_gpioValue;
    logic [15:0] gpioMask_ff, nxt_gpioMask;
    logic [15:0] eepCtrl_ff, nxt_eepCtrl;
    logic [1:0] strapMeta_ff;
    logic [1:0] strapSync_ff;
    logic wbAck_ff;
    logic [WB_DAT_W-1:0] wbDat_ff;
    logic [15:0] pinOut_ff;
    logic [15:0] pinOe_ff;
    logic eepWrEn_ff;
    logic [7:0] eepWrAddr_ff;
    logic [15:0] eepWrData_ff;
    logic eepRefused_ff;
    logic [3:0] svcDis_ff;
    logic [3:0] useCode_ff;
    logic mibMode_ff;
    logic descrBusy;
    logic oidBusy;

    function automatic logic [15:0] apply_bytes(input logic [15:0] old,
                                                input logic [15:0] dat,
                                                input logic [1:0] sel);
        logic [15:0] res;
        res = old;
        if (sel[0])
        begin
            res[7:0] = dat[7:0];
        end
        if (sel[1])
        begin
            res[15:8] = dat[15:8];
        end
        return res;
    endfunction

    // bus decode: byte address is four times the register index
    wire logic [5:0] wbIdx = wbReq.adr[WB_ADR_W-1:2];
    wire logic wbReqOn = wbReq.cyc && wbReq.stb;
    wire logic wbWrFire = wbReqOn && wbReq.we && wbAck_ff;
    wire logic wrGpioValue = wbWrFire && (wbIdx == IDX_GPIO_VALUE);
    wire logic wrGpioMask = wbWrFire && (wbIdx == IDX_GPIO_MASK);
    wire logic wrEepCtrl = wbWrFire && (wbIdx == IDX_EEP_CTRL);
    wire logic [15:0] wbDat16 = wbReq.dat[15:0];
    wire logic [1:0] wbSel16 = wbReq.sel[1:0];
    wire logic [15:0] statusWord = {13'h0000, mibMode_ff, oidBusy, descrBusy};
    wire logic [15:0] rdWord = (wbIdx == IDX_GPIO_VALUE) ? gpioValue_ff :
                               (wbIdx == IDX_GPIO_MASK) ? gpioMask_ff :
                               (wbIdx == IDX_EEP_CTRL) ? eepCtrl_ff :
                               (wbIdx == IDX_STATUS) ? statusWord : 16'h0000;

    // strap-dependent reset value of the output register
    wire logic [15:0] gpioRstVal = (strapSync_ff == SER_HWCTL) ? GPIO_RST_HWCTL :
                                   (strapSync_ff == SER_EMUL) ? GPIO_RST_EMUL :
                                   GPIO_RST_NONE;

    // alternate functions pin single bits high
    wire logic oscAlt = gpioAltSelect[OSC_ALT_BIT];
    wire logic serialAlt = (gpioAltSelect[15:8] == SERIAL_ALT_ALL);
    wire logic [15:0] forceVec = (oscAlt ? FORCE_OSC_MASK : 16'h0000)
                               | (serialAlt ? FORCE_TXD_MASK : 16'h0000);

    // network may touch a bit unless it is masked and the pin drives
    wire logic [15:0] netBlock = gpioMask_ff & gpioDirection;
    wire logic [15:0] netAllow = ~netBlock;
    wire logic [15:0] busGpio = wrGpioValue ?
                                apply_bytes(gpioValue_ff, wbDat16, wbSel16) : gpioValue_ff;
    // a network write landing with a bus write wins on the bits it may change
    wire logic [15:0] netGpio = netGpioWr.valid ?
                                ((busGpio & netBlock) | (netGpioWr.data & netAllow)) :
                                busGpio;

    // eeprom writes below the protect index never reach the eeprom
    wire logic [7:0] protectIdx = eepCtrl_ff[7:0];
    wire logic eepAllowed = (netEepWr.idx >= protectIdx);
    wire logic mibMode = (eepCtrl_ff[USE_MSB:USE_LSB] == USE_MIB);

    always_comb
    begin
        nxt_gpioValue = netGpio | forceVec;
        nxt_gpioMask = wrGpioMask ? apply_bytes(gpioMask_ff, wbDat16, wbSel16) : gpioMask_ff;
        nxt_eepCtrl = wrEepCtrl ? apply_bytes(eepCtrl_ff, wbDat16, wbSel16) : eepCtrl_ff;
    end

    // strap comes from a pin: no reset so it settles while reset is held
    always_ff @(posedge clk_sys)
    begin
        strapMeta_ff <= serialStrap;
        strapSync_ff <= strapMeta_ff;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            gpioValue_ff <= gpioRstVal;
            gpioMask_ff <= GPIO_MASK_RST;
            eepCtrl_ff <= EEP_CTRL_RST;
        end
        else
        begin
            gpioValue_ff <= nxt_gpioValue;
            gpioMask_ff <= nxt_gpioMask;
            eepCtrl_ff <= nxt_eepCtrl;
        end
    end

    // one wait state, ack held a single cycle
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            wbAck_ff <= 1'b0;
            wbDat_ff <= 32'h0000_0000;
        end
        else
        begin
            wbAck_ff <= wbReqOn && !wbAck_ff;
            wbDat_ff <= (wbReqOn && !wbAck_ff) ? {16'h0000, rdWord} : 32'h0000_0000;
        end
    end

    // pin shows the stored value only while it is an output
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            pinOut_ff <= 16'h0000;
            pinOe_ff <= 16'h0000;
        end
        else
        begin
            pinOut_ff <= gpioValue_ff & gpioDirection;
            pinOe_ff <= gpioDirection;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            eepWrEn_ff <= 1'b0;
            eepWrAddr_ff <= 8'h00;
            eepWrData_ff <= 16'h0000;
            eepRefused_ff <= 1'b0;
        end
        else
        begin
            eepWrEn_ff <= netEepWr.valid && eepAllowed;
            eepRefused_ff <= netEepWr.valid && !eepAllowed;
            if (netEepWr.valid && eepAllowed)
            begin
                eepWrAddr_ff <= netEepWr.idx;
                eepWrData_ff <= netEepWr.data;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            svcDis_ff <= 4'h0;
            useCode_ff <= USE_FREE;
            mibMode_ff <= 1'b0;
        end
        else
        begin
            svcDis_ff <= eepCtrl_ff[ECHO_DIS_BIT:MGMT_DIS_BIT];
            useCode_ff <= eepCtrl_ff[USE_MSB:USE_LSB];
            mibMode_ff <= mibMode;
        end
    end

    // reserved usage codes leave the user area uninterpreted
    string_scanner #(
        .START_WORD(DESCR_START_WORD),
        .MAX_BYTES(DESCR_MAX_BYTES)
    ) u_descr (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .start(descrStart),
        .enable(mibMode),
        .rdData(descrRdData),
        .rdReq(descrRdReq),
        .rdAddr(descrRdAddr),
        .strByte(descrByte),
        .busy(descrBusy)
    );

    string_scanner #(
        .START_WORD(OID_START_WORD),
        .MAX_BYTES(OID_MAX_BYTES)
    ) u_oid (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .start(oidStart),
        .enable(mibMode),
        .rdData(oidRdData),
        .rdReq(oidRdReq),
        .rdAddr(oidRdAddr),
        .strByte(oidByte),
        .busy(oidBusy)
    );

    assign wbDatO = wbDat_ff;
    assign wbAck = wbAck_ff;
    assign gpioPinOut = pinOut_ff;
    assign gpioPinOe = pinOe_ff;
    assign eepWrEn = eepWrEn_ff;
    assign eepWrAddr = eepWrAddr_ff;
    assign eepWrData = eepWrData_ff;
    assign eepWrRefused = eepRefused_ff;
    assign echoReplyDisable = svcDis_ff[3];
    assign fileTransferDisable = svcDis_ff[2];
    assign webServerDisable = svcDis_ff[1];
    assign mgmtServerDisable = svcDis_ff[0];
    assign eepromUsageCode = useCode_ff;
    assign mibModeActive = mibMode_ff;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    a_pin_follows_value: assert property (
        ##1 gpioPinOut == ($past(gpioValue_ff) & $past(gpioDirection))
    ) else $error("pin level does not follow stored value and direction");

    a_reset_value_strap: assert property (
        $rose(resetn) |-> gpioValue_ff == $past(gpioRstVal)
    ) else $error("output register reset value ignores serial strap");

    a_osc_bit_forced: assert property (
        gpioAltSelect[OSC_ALT_BIT] |=> gpioValue_ff[OSC_ALT_BIT]
    ) else $error("oscillator control bit not forced high");

    a_txd_bit_forced: assert property (
        (gpioAltSelect[15:8] == SERIAL_ALT_ALL) |=> gpioValue_ff[TXD_BIT]
    ) else $error("transmit data bit not forced high");

    a_mask_blocks_net: assert property (
        (netGpioWr.valid && !wrGpioValue)
        |=> ((gpioValue_ff ^ $past(gpioValue_ff)) & $past(netBlock & ~forceVec)) == 16'h0000
    ) else $error("masked output bit changed by network write");

    a_unmasked_net_update: assert property (
        netGpioWr.valid
        |=> (gpioValue_ff & $past(netAllow & ~forceVec))
            == ($past(netGpioWr.data) & $past(netAllow & ~forceVec))
    ) else $error("allowed output bit not updated by network write");

    a_eep_refuse_low: assert property (
        (netEepWr.valid && netEepWr.idx < eepCtrl_ff[7:0]) |=> eepWrRefused && !eepWrEn
    ) else $error("protected eeprom index was written");

    a_eep_accept_high: assert property (
        (netEepWr.valid && netEepWr.idx >= eepCtrl_ff[7:0])
        |=> eepWrEn && eepWrAddr == $past(netEepWr.idx) && !eepWrRefused
    ) else $error("unprotected eeprom write not passed on");

    a_service_gates: assert property (
        ##1 {echoReplyDisable, fileTransferDisable, webServerDisable, mgmtServerDisable}
            == $past(eepCtrl_ff[ECHO_DIS_BIT:MGMT_DIS_BIT])
    ) else $error("service disable outputs do not follow control register");

    a_mib_gate_start: assert property (
        (descrStart && !descrBusy && !mibMode) |=> !descrRdReq && !descrBusy
    ) else $error("description read started outside MIB mode");

    a_ack_one_cycle: assert property (
        wbAck |=> !wbAck
    ) else $error("bus ack held longer than one cycle");

    c_net_gpio_masked: cover property (netGpioWr.valid && (netBlock != 16'h0000));
    c_eep_refused: cover property (eepWrRefused);
    c_descr_full: cover property (descrByte.last);
    c_oid_zero_end: cover property (oidByte.done && !oidByte.last);
endmodule
`default_nettype wire

// ---- gpio_mask_pkg.sv ----
// constants, types and field layout of the gpio output and access mask registers
package gpio_mask_pkg;
    localparam int WB_ADR_W = 8;
    localparam int WB_DAT_W = 32;
    localparam logic [5:0] IDX_GPIO_VALUE = 6'h0a;
    localparam logic [5:0] IDX_GPIO_MASK = 6'h0b;
    localparam logic [5:0] IDX_EEP_CTRL = 6'h0c;
    localparam logic [5:0] IDX_STATUS = 6'h10;
    localparam logic [1:0] SER_NONE = 2'h0;
    localparam logic [1:0] SER_HWCTL = 2'h1;
    localparam logic [1:0] SER_EMUL = 2'h2;
    localparam logic [15:0] GPIO_RST_HWCTL = 16'h8200;
    localparam logic [15:0] GPIO_RST_EMUL = 16'h0200;
    localparam logic [15:0] GPIO_RST_NONE = 16'h0000;
    localparam logic [15:0] GPIO_MASK_RST = 16'h0000;
    localparam logic [15:0] EEP_CTRL_RST = 16'h0000;
    localparam int OSC_ALT_BIT = 7;
    localparam int TXD_BIT = 9;
    localparam logic [15:0] FORCE_OSC_MASK = 16'h0080;
    localparam logic [15:0] FORCE_TXD_MASK = 16'h0200;
    localparam logic [7:0] SERIAL_ALT_ALL = 8'hff;
    localparam int USE_MSB = 15;
    localparam int USE_LSB = 12;
    localparam int ECHO_DIS_BIT = 11;
    localparam int FTP_DIS_BIT = 10;
    localparam int WEB_DIS_BIT = 9;
    localparam int MGMT_DIS_BIT = 8;
    localparam logic [3:0] USE_FREE = 4'h0;
    localparam logic [3:0] USE_MIB = 4'h8;
    localparam int DESCR_START_WORD = 40;
    localparam int DESCR_MAX_BYTES = 40;
    localparam int OID_START_WORD = 60;
    localparam int OID_MAX_BYTES = 8;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [WB_ADR_W-1:0] adr;
        logic [3:0] sel;
        logic [WB_DAT_W-1:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } net_gpio_wr_t;

    typedef struct packed {
        logic valid;
        logic [7:0] idx;
        logic [15:0] data;
    } net_eep_wr_t;

    typedef struct packed {
        logic valid;
        logic last;
        logic done;
        logic [7:0] data;
    } str_byte_t;
endpackage

// ---- string_scanner.sv ----
// reads a zero-terminated byte string out of consecutive eeprom words
`timescale 1ns/1ns
`default_nettype none
module string_scanner
    import gpio_mask_pkg::*;
#(
    parameter int unsigned START_WORD = 40,
    parameter int unsigned MAX_BYTES = 40
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic start,
    input wire logic enable,
    input wire logic [15:0] rdData,
    output logic rdReq,
    output logic [7:0] rdAddr,
    output str_byte_t strByte,
    output logic busy
);
    localparam int CW = $clog2(MAX_BYTES + 1);

    if (MAX_BYTES < 1 || START_WORD + (MAX_BYTES + 1) / 2 > 256)
    begin : g_chk
        $error("string_scanner: string does not fit the eeprom index range");
    end

    typedef enum logic [3:0] {
        SC_IDLE = 4'b0001,
        SC_READ = 4'b0010,
        SC_CAPT = 4'b0100,
        SC_EMIT = 4'b1000
    } scan_state_t;

    scan_state_t state_ff, nxt_state;
    logic rdReq_ff, nxt_rdReq;
    logic [7:0] addr_ff, nxt_addr;
    logic [15:0] word_ff, nxt_word;
    logic half_ff, nxt_half;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    str_byte_t byte_ff, nxt_byte;
    logic busy_ff;

    // earlier byte sits in the low half
    wire logic [7:0] curByte = half_ff ? word_ff[15:8] : word_ff[7:0];
    wire logic [CW-1:0] cntInc = cnt_ff + CW'(1);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_rdReq = 1'b0;
        nxt_addr = addr_ff;
        nxt_word = word_ff;
        nxt_half = half_ff;
        nxt_cnt = cnt_ff;
        nxt_byte = '0;
        case (state_ff)
            SC_IDLE:
            begin
                if (start && enable)
                begin
                    nxt_state = SC_READ;
                    nxt_rdReq = 1'b1;
                    nxt_addr = START_WORD[7:0];
                    nxt_half = 1'b0;
                    nxt_cnt = '0;
                end
            end
            SC_READ: nxt_state = SC_CAPT;
            SC_CAPT:
            begin
                nxt_word = rdData;
                nxt_state = SC_EMIT;
            end
            SC_EMIT:
            begin
                if (curByte == 8'h00)
                begin
                    // terminator is not passed on
                    nxt_byte.done = 1'b1;
                    nxt_state = SC_IDLE;
                end
                else
                begin
                    nxt_byte.valid = 1'b1;
                    nxt_byte.data = curByte;
                    nxt_cnt = cntInc;
                    if (cntInc == CW'(MAX_BYTES))
                    begin
                        nxt_byte.last = 1'b1;
                        nxt_byte.done = 1'b1;
                        nxt_state = SC_IDLE;
                    end
                    else if (half_ff)
                    begin
                        nxt_half = 1'b0;
                        nxt_addr = addr_ff + 8'h01;
                        nxt_rdReq = 1'b1;
                        nxt_state = SC_READ;
                    end
                    else
                    begin
                        nxt_half = 1'b1;
                    end
                end
            end
            default: nxt_state = SC_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            state_ff <= SC_IDLE;
            rdReq_ff <= 1'b0;
            addr_ff <= 8'h00;
            word_ff <= 16'h0000;
            half_ff <= 1'b0;
            cnt_ff <= '0;
            byte_ff <= '0;
            busy_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            rdReq_ff <= nxt_rdReq;
            addr_ff <= nxt_addr;
            word_ff <= nxt_word;
            half_ff <= nxt_half;
            cnt_ff <= nxt_cnt;
            byte_ff <= nxt_byte;
            busy_ff <= (nxt_state != SC_IDLE);
        end
    end

    assign rdReq = rdReq_ff;
    assign rdAddr = addr_ff;
    assign strByte = byte_ff;
    assign busy = busy_ff;
endmodule
`default_nettype wire

// ---- eeprom_word_model.sv ----
// eeprom partner answering the two string reader ports
`timescale 1ns/1ns
`default_nettype none
module eeprom_word_model
(
    input wire logic clk_sys,
    input wire logic descrRdReq,
    input wire logic [7:0] descrRdAddr,
    input wire logic oidRdReq,
    input wire logic [7:0] oidRdAddr,
    output logic [15:0] descrRdData,
    output logic [15:0] oidRdData
);
    // bench loads strings low byte first, ber id, bit 15 of word 3fh clear
    logic [15:0] mem [0:255];
    // word valid one cycle after request; inverted otherwise so stale reads show
    always @(posedge clk_sys)
    begin
        descrRdData <= descrRdReq ? mem[descrRdAddr] : ~descrRdData;
        oidRdData <= oidRdReq ? mem[oidRdAddr] : ~oidRdData;
    end
endmodule
`default_nettype wire

// ---- gpio_output_and_access_masks_tb.sv ----
// self-checking bench for the gpio output and access mask registers
`timescale 1ns/1ns
`default_nettype none
module gpio_output_and_access_masks_tb;
    import gpio_mask_pkg::*;
    wb_req_t wbReq;
    net_gpio_wr_t netGpioWr;
    net_eep_wr_t netEepWr;
    str_byte_t descrByte, oidByte, sb;
    logic [31:0] wbDatO, rd, seed;
    logic [15:0] gpioDirection, gpioAltSelect, gpioPinOut, gpioPinOe, eepWrData;
    logic [15:0] descrRdData, oidRdData, dir, alt, val, msk, nd, exp;
    logic [7:0] eepWrAddr, descrRdAddr, oidRdAddr, idx;
    logic [3:0] eepromUsageCode;
    logic [1:0] serialStrap;
    logic clk_sys, resetn, wbAck, eepWrEn, eepWrRefused, echoReplyDisable;
    logic fileTransferDisable, webServerDisable, mgmtServerDisable, mibModeActive;
    logic descrStart, oidStart, descrRdReq, oidRdReq, watchOid, doneSeen, lastSeen;
    logic [7:0] src [0:47];
    logic [7:0] gotQ [$];
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;

    gpio_output_and_access_masks dut_u (.clk_sys, .resetn, .wbReq, .wbDatO, .wbAck,
        .serialStrap, .gpioDirection, .gpioAltSelect, .netGpioWr, .netEepWr, .gpioPinOut,
        .gpioPinOe, .eepWrEn, .eepWrAddr, .eepWrData, .eepWrRefused, .echoReplyDisable,
        .fileTransferDisable, .webServerDisable, .mgmtServerDisable, .eepromUsageCode,
        .mibModeActive, .descrStart, .oidStart, .descrRdData, .oidRdData, .descrRdReq,
        .descrRdAddr, .oidRdReq, .oidRdAddr, .descrByte, .oidByte);
    eeprom_word_model mem_u (.clk_sys, .descrRdReq, .descrRdAddr, .oidRdReq, .oidRdAddr,
        .descrRdData, .oidRdData);

    assign sb = watchOid ? oidByte : descrByte;

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // hang guard well above the several hundred cycles the run needs
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            fails++;
            end_of_test();
        end
    end

    always @(posedge clk_sys)
    begin
        if (sb.valid === 1'b1)
            gotQ.push_back(sb.data);
        if (sb.valid === 1'b1 && sb.last === 1'b1)
            lastSeen = 1'b1;
        if (sb.done === 1'b1)
            doneSeen = 1'b1;
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction

    // refused bits kept, forced bits 7 and 9 on top
    function automatic logic [15:0] merged(input logic [15:0] o, d, m, dr, al);
        return (o & m & dr) | (d & ~(m & dr)) | {6'h00, &al[15:8], 1'b0, al[7], 7'h00};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        comparisons++;
        if (got !== want)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    task automatic wb(input logic we, input logic [5:0] ix, input logic [15:0] d);
        @(posedge clk_sys);
        wbReq <= '{1'b1, 1'b1, we, {ix, 2'b00}, 4'h3, {16'h0000, d}};
        do @(posedge clk_sys); while (wbAck !== 1'b1);
        rd = wbDatO;
        wbReq <= '0;
    endtask

    task automatic set_src(input logic [63:0] pat);
        for (int i = 0; i < 8; i++)
            src[i] = pat[8 * i +: 8];
    endtask

    task automatic run_str(input bit isOid, input int nSrc, input int nExp);
        gotQ = {};
        doneSeen = 1'b0;
        lastSeen = 1'b0;
        watchOid = isOid;
        for (int i = 0; i < nSrc; i += 2)
            mem_u.mem[(isOid ? 8'h3C : 8'h28) + i / 2] = {src[i + 1], src[i]};
        @(posedge clk_sys);
        if (isOid)
            oidStart <= 1'b1;
        else
            descrStart <= 1'b1;
        @(posedge clk_sys);
        descrStart <= 1'b0;
        oidStart <= 1'b0;
        for (int i = 0; i < 300 && !doneSeen; i++)
            @(posedge clk_sys);
        chk(gotQ.size(), nExp);
        for (int i = 0; i < nExp; i++)
            chk(gotQ[i], src[i]);
        chk(lastSeen, nExp == (isOid ? 8 : 40));
    endtask

    task automatic end_of_test();
        if (fails == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        resetn = 1'b0;
        wbReq = '0;
        netGpioWr = '0;
        netEepWr = '0;
        serialStrap = 2'h0;
        gpioDirection = 16'h0000;
        gpioAltSelect = 16'h0000;
        descrStart = 1'b0;
        oidStart = 1'b0;
        watchOid = 1'b0;
        seed = 32'h0001_1213;
        for (int i = 0; i < 256; i++)
            mem_u.mem[i] = 16'h0000;
        for (int s = 0; s < 4; s++)
        begin
            serialStrap <= s[1:0];
            resetn <= 1'b0;
            repeat (10) @(posedge clk_sys);
            resetn <= 1'b1;
            wb(1'b0, 6'h0a, 16'h0000);
            chk(rd, s == 1 ? 32'h0000_8200 : s == 2 ? 32'h0000_0200 : 32'h0000_0000);
            wb(1'b0, 6'h0b, 16'h0000);
            chk(rd, 32'h0000_0000);
            chk(gpioPinOe, 16'h0000);
        end
        for (int i = 0; i < 12; i++)
        begin
            seed = xs(seed);
            dir = seed[15:0];
            alt = {{8{seed[16]}}, seed[17], 7'h00};
            val = seed[31:16];
            gpioDirection <= dir;
            gpioAltSelect <= alt;
            wb(1'b1, 6'h0a, val);
            wb(1'b0, 6'h0a, 16'h0000);
            exp = merged(val, val, 16'h0000, dir, alt);
            chk(rd, exp);
            chk(gpioPinOut, exp & dir);
            chk(gpioPinOe, dir);
        end
        gpioAltSelect <= 16'h0000;
        for (int i = 0; i < 12; i++)
        begin
            seed = xs(seed);
            msk = i == 0 ? 16'hFFFF : seed[15:0];
            dir = i == 0 ? 16'h00FF : seed[31:16];
            seed = xs(seed);
            val = seed[15:0];
            nd = seed[31:16];
            gpioDirection <= dir;
            wb(1'b1, 6'h0b, msk);
            wb(1'b1, 6'h0a, val);
            @(posedge clk_sys);
            netGpioWr <= '{1'b1, nd};
            @(posedge clk_sys);
            netGpioWr <= '0;
            wb(1'b0, 6'h0a, 16'h0000);
            chk(rd, merged(val, nd, msk, dir, 16'h0000));
            wb(1'b0, 6'h0b, 16'h0000);
            chk(rd, msk);
        end
        for (int i = 0; i < 8; i++)
        begin
            seed = xs(seed);
            val = {i[0] ? 4'h8 : seed[15:12], seed[11:0]};
            wb(1'b1, 6'h0c, val);
            wb(1'b0, 6'h0c, 16'h0000);
            chk(rd, val);
            chk({echoReplyDisable, fileTransferDisable, webServerDisable,
                mgmtServerDisable}, val[11:8]);
            chk({eepromUsageCode, mibModeActive}, {val[15:12], val[15:12] == 4'h8});
            // boundary pair first: one below the index, then the index itself
            for (int j = 0; j < 3; j++)
            begin
                idx = j == 2 ? seed[23:16] : val[7:0] - 8'(j == 0);
                @(posedge clk_sys);
                netEepWr <= '{1'b1, idx, seed[31:16]};
                @(posedge clk_sys);
                netEepWr <= '0;
                @(posedge clk_sys);
                chk({eepWrEn, eepWrRefused}, {idx >= val[7:0], idx < val[7:0]});
                if (idx >= val[7:0])
                    chk({eepWrAddr, eepWrData}, {idx, seed[31:16]});
            end
        end
        wb(1'b1, 6'h3f, 16'h1234);
        wb(1'b0, 6'h3f, 16'h0000);
        chk(rd, 32'h0000_0000);
        wb(1'b1, 6'h0c, 16'h0000);
        set_src(64'h0000_0000_7473_6574);
        run_str(1'b0, 6, 0);
        wb(1'b1, 6'h0c, 16'h8000);
        wb(1'b0, 6'h10, 16'h0000);
        chk(rd, 32'h0000_0004);
        run_str(1'b0, 6, 4);
        for (int i = 0; i < 40; i++)
            src[i] = 8'h20 + 8'(i);
        run_str(1'b0, 40, 40);
        set_src(64'h0000_0101_0105_6089);
        run_str(1'b1, 8, 6);
        set_src(64'h7877_6665_5453_4241);
        run_str(1'b1, 8, 8);
        end_of_test();
    end
endmodule
`default_nettype wire
